// [rtl/adaptive_ambient_calibration.v]
// per-stage ambient tracking, slow filter gating and adaptive threshold engine
`timescale 1ns/1ps
`default_nettype none
`include "ambient_cal_consts.vh"

// What this block does
// - ambient drift measured per stage shifts that stage's upper and lower offsets.
// - after offsets move, both limits are recomputed from them in the same pass.
// - slow filter ambient and last push of every stage live in the bank 3 memory.
// - control word 0x001 holds full-power skip at 13:12, low-power skip at 15:14.
// - skip fields choose how many converter samples are dropped before the slow filter.
// - full-power update period is full-power skip code plus three dropped samples, then one push.
// - low-power update period is low-power skip plus one samples of that stage.
// - word 0x003 bits 15:14 set minimum change needed before a slow filter push.
// - limits are referenced to ambient; contact only when output passes a limit.
// - limits are a percentage of the response, or of offsets until averages open up, chosen by sensitivity, around ambient.
// - average maximum and minimum are tracked; limits rescale when either moves.
// - four-bit sensitivity code picks one of 16 levels from 25% to 95.32%.
// - code 1000 places the upper limit at about 62.51% of the response.
// - minimum average updates only when output is within the lower peak window.
// - maximum average updates only when output is within the upper peak window.
// - ambient used in both limit equations is the slow-filtered untouched output.
module adaptive_ambient_calibration (
    input wire clock_i,
    input wire rst_n_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [`ADDR_W-1:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    input wire sample_valid_i,
    input wire [2:0] sample_stage_i,
    input wire [15:0] sample_data_i,
    input wire low_power_i,
    output reg busy_o,
    output reg [7:0] contact_o
);

    localparam S_IDLE = 2'b00;
    localparam S_READ = 2'b01;
    localparam S_WRITE = 2'b10;

    // sensitivity or peak code to a fraction of 1024
    function [9:0] pct;
        input [3:0] code;
        begin
            pct = `PCT_BASE + code * `PCT_STEP;
        end
    endfunction

    // scale a response by a code's fraction
    function [15:0] scale;
        input [15:0] span;
        input [3:0] code;
        reg [25:0] prod;
        begin
            prod = span * pct(code);
            scale = prod[25:`PCT_SHIFT];
        end
    endfunction

    reg [15:0] ctrl_a;
    reg [15:0] ctrl_c;
    reg [15:0] upper_off [0:7];
    reg [15:0] lower_off [0:7];
    reg [15:0] sens [0:7];
    reg [2:0] skip_cnt [0:7];
    reg [7:0] seeded;
    reg [1:0] state;
    reg [2:0] idx;
    reg [2:0] stage;
    reg [15:0] smp;
    reg [15:0] amb;
    reg [15:0] lastp;
    reg [15:0] amax;
    reg [15:0] amin;

    wire [15:0] ram_rdata;
    reg [15:0] ram_wdata;
    wire ram_we;
    wire [`BANK3_AW-1:0] ram_addr;
    wire [2:0] stage_sel;
    wire [1:0] field_sel;
    wire stage_hit;
    integer i;

    // per-stage ambient, last push, averages and limits sit in one memory
    bank3_ram #(
        .WIDTH(16),
        .DEPTH(`BANK3_DEPTH),
        .AW(`BANK3_AW)
    ) u_bank3 (
        .clock_i(clock_i),
        .wr_en_i(ram_we),
        .addr_i(ram_addr),
        .wr_data_i(ram_wdata),
        .rd_data_o(ram_rdata)
    );

    assign ram_we = (state == S_WRITE);
    assign ram_addr = {stage, idx};

    // host access decode for the per-stage words
    assign stage_hit = (reg_addr_i >= `ADDR_STAGE_BASE) && (reg_addr_i <= `ADDR_STAGE_TOP);
    assign stage_sel = reg_addr_i[4:2];
    assign field_sel = reg_addr_i[1:0];

    // effective stored values; an unseeded stage starts from its first sample
    wire first = ~seeded[stage];
    wire [15:0] e_amb = first ? smp : amb;
    wire [15:0] e_last = first ? smp : lastp;
    wire [15:0] e_max = first ? smp : amax;
    wire [15:0] e_min = first ? smp : amin;
    wire [15:0] sw = sens[stage];
    wire [3:0] up_code = sw[`UPPER_SENS_HI:`UPPER_SENS_LO];
    wire [3:0] lo_code = sw[`LOWER_SENS_HI:`LOWER_SENS_LO];
    wire [3:0] up_peak = sw[`UPPER_PEAK_HI:`UPPER_PEAK_LO];
    wire [3:0] lower_peak_window = sw[`LOWER_PEAK_HI:`LOWER_PEAK_LO];

    // slow filter skip: full power drops base plus code samples, low power drops code
    wire [1:0] slow_skip_full_power = ctrl_a[`FP_SKIP_HI:`FP_SKIP_LO];
    wire [1:0] slow_skip_low_power = ctrl_a[`LP_SKIP_HI:`LP_SKIP_LO];
    wire [2:0] skip_target = low_power_i ? {1'b0, slow_skip_low_power}
                                         : `FP_SKIP_BASE + {1'b0, slow_skip_full_power};
    wire skip_hit = (skip_cnt[stage] >= skip_target);

    // responses above and below ambient; fall back to host offsets until averages open up
    wire [15:0] span_up = (e_max > e_amb) ? e_max - e_amb : upper_off[stage];
    wire [15:0] span_dn = (e_min < e_amb) ? e_amb - e_min : lower_off[stage];
    wire [15:0] up_lim_now = e_amb + scale(span_up, up_code);
    wire [15:0] lo_lim_now = e_amb - scale(span_dn, lo_code);
    wire touched = (smp > up_lim_now) || (smp < lo_lim_now);

    // slow filter push gate: change since last push must exceed the update level
    wire [1:0] slow_push_min_delta = ctrl_c[`PUSH_LVL_HI:`PUSH_LVL_LO];
    wire [15:0] push_delta = (smp > e_last) ? smp - e_last : e_last - smp;
    wire push = skip_hit && (push_delta > {14'h0000, slow_push_min_delta}) && ~touched;

    // ambient follows the pushed samples; only untouched samples get
    wire [16:0] amb_err = {1'b0, smp} - {1'b0, e_amb};
    wire [16:0] amb_step = $signed(amb_err) >>> `AMB_SHIFT;
    wire [15:0] next_amb = push ? e_amb + amb_step[15:0] : e_amb;
    wire [15:0] drift = next_amb - e_amb; // two's complement drift

    // offsets ride along with the ambient drift
    wire [15:0] next_upper_off = upper_off[stage] + drift;
    wire [15:0] next_lower_off = lower_off[stage] - drift;

    // peak tracking windows around the current averages
    wire [15:0] max_eff = e_amb + span_up;
    wire [15:0] min_eff = e_amb - span_dn;
    wire near_max = (smp > e_amb) && (smp >= max_eff - scale(span_up, up_peak));
    wire near_min = (smp < e_amb) && (smp <= min_eff + scale(span_dn, lower_peak_window));
    wire [16:0] max_sum = {1'b0, max_eff} + {1'b0, smp};
    wire [16:0] min_sum = {1'b0, min_eff} + {1'b0, smp};
    wire [15:0] next_max = near_max ? max_sum[16:1] : e_max;
    wire [15:0] next_min = near_min ? min_sum[16:1] : e_min;

    // limits recomputed from the new ambient, averages and shifted offsets
    wire [15:0] nspan_up = (next_max > next_amb) ? next_max - next_amb : next_upper_off;
    wire [15:0] nspan_dn = (next_min < next_amb) ? next_amb - next_min : next_lower_off;
    wire [15:0] stage_upper_limit = next_amb + scale(nspan_up, up_code);
    wire [15:0] stage_lower_limit = next_amb - scale(nspan_dn, lo_code);

    // write-back data for the bank 3 words of this stage
    always @* begin
        case (idx)
            `WORD_AMBIENT: ram_wdata = next_amb;
            `WORD_LAST_PUSH: ram_wdata = push ? smp : e_last;
            `WORD_AVG_MAX: ram_wdata = next_max;
            `WORD_AVG_MIN: ram_wdata = next_min;
            `WORD_UPPER_LIMIT: ram_wdata = stage_upper_limit;
            default: ram_wdata = stage_lower_limit;
        endcase
    end

    // sequencer: read four words, then write six; samples offered while busy_o is high are dropped
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= S_IDLE;
            idx <= 3'h0;
            stage <= 3'h0;
            smp <= 16'h0000;
            amb <= 16'h0000;
            lastp <= 16'h0000;
            amax <= 16'h0000;
            amin <= 16'h0000;
            busy_o <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    idx <= 3'h0;
                    if (sample_valid_i) begin
                        stage <= sample_stage_i;
                        smp <= sample_data_i;
                        state <= S_READ;
                        busy_o <= 1'b1;
                    end
                end
                S_READ: begin
                    // read data lags the address by one cycle
                    case (idx)
                        3'h1: amb <= ram_rdata;
                        3'h2: lastp <= ram_rdata;
                        3'h3: amax <= ram_rdata;
                        3'h4: amin <= ram_rdata;
                        default: amb <= amb;
                    endcase
                    if (idx == `READ_LAST) begin
                        idx <= 3'h0;
                        state <= S_WRITE;
                    end else begin
                        idx <= idx + 3'h1;
                    end
                end
                S_WRITE: begin
                    if (idx == `WRITE_LAST) begin
                        idx <= 3'h0;
                        state <= S_IDLE;
                        busy_o <= 1'b0;
                    end else begin
                        idx <= idx + 3'h1;
                    end
                end
                default: begin
                    state <= S_IDLE;
                    busy_o <= 1'b0;
                end
            endcase
        end
    end

    // control words, per-stage host words and per-stage engine state
    // a host write to an offset wins over the engine's drift update in the same cycle
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_a <= `CTRL_A_RESET;
            ctrl_c <= `CTRL_C_RESET;
            seeded <= 8'h00;
            contact_o <= 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                upper_off[i] <= `OFFSET_RESET;
                lower_off[i] <= `OFFSET_RESET;
                sens[i] <= `SENS_RESET;
                skip_cnt[i] <= 3'h0;
            end
        end else begin
            // end of a pass: commit per-stage flops
            if (state == S_WRITE && idx == `WRITE_LAST) begin
                seeded[stage] <= 1'b1;
                contact_o[stage] <= touched;
                upper_off[stage] <= next_upper_off;
                lower_off[stage] <= next_lower_off;
                skip_cnt[stage] <= skip_hit ? 3'h0 : skip_cnt[stage] + 3'h1;
            end
            if (reg_wr_i) begin
                if (reg_addr_i == `ADDR_CTRL_A) begin
                    ctrl_a <= reg_wdata_i;
                end else if (reg_addr_i == `ADDR_CTRL_C) begin
                    ctrl_c <= reg_wdata_i;
                end else if (stage_hit && field_sel == `STAGE_FIELD_UPPER_OFF) begin
                    upper_off[stage_sel] <= reg_wdata_i;
                end else if (stage_hit && field_sel == `STAGE_FIELD_LOWER_OFF) begin
                    lower_off[stage_sel] <= reg_wdata_i;
                end else if (stage_hit && field_sel == `STAGE_FIELD_SENS) begin
                    sens[stage_sel] <= reg_wdata_i;
                end
            end
        end
    end

    // register read: data one cycle after the strobe, zero for unmapped words
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `ADDR_CTRL_A) begin
                reg_rdata_o <= ctrl_a;
            end else if (reg_addr_i == `ADDR_CTRL_C) begin
                reg_rdata_o <= ctrl_c;
            end else if (reg_addr_i == `ADDR_CONTACT) begin
                reg_rdata_o <= {8'h00, contact_o};
            end else if (stage_hit && field_sel == `STAGE_FIELD_UPPER_OFF) begin
                reg_rdata_o <= upper_off[stage_sel];
            end else if (stage_hit && field_sel == `STAGE_FIELD_LOWER_OFF) begin
                reg_rdata_o <= lower_off[stage_sel];
            end else if (stage_hit && field_sel == `STAGE_FIELD_SENS) begin
                reg_rdata_o <= sens[stage_sel];
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end
    end

endmodule
`default_nettype wire

// [rtl/ambient_cal_consts.vh]
// constants for the ambient calibration and adaptive threshold block
`ifndef AMBIENT_CAL_CONSTS_VH
`define AMBIENT_CAL_CONSTS_VH

// register map, word addresses on the register port
`define ADDR_W 10
`define ADDR_CTRL_A 10'h001
`define ADDR_CTRL_C 10'h003
`define ADDR_CONTACT 10'h040
`define ADDR_STAGE_BASE 10'h080
`define ADDR_STAGE_TOP 10'h09F
`define STAGE_FIELD_UPPER_OFF 2'h0
`define STAGE_FIELD_LOWER_OFF 2'h1
`define STAGE_FIELD_SENS 2'h2

// reset values
`define CTRL_A_RESET 16'h0000
`define CTRL_C_RESET 16'h0000
`define OFFSET_RESET 16'h0000
`define SENS_RESET 16'h0000

// field positions in ambient_comp_control_a / _c
`define FP_SKIP_HI 13
`define FP_SKIP_LO 12
`define LP_SKIP_HI 15
`define LP_SKIP_LO 14
`define PUSH_LVL_HI 15
`define PUSH_LVL_LO 14

// field positions in a stage sensitivity word
`define LOWER_SENS_HI 3
`define LOWER_SENS_LO 0
`define UPPER_SENS_HI 7
`define UPPER_SENS_LO 4
`define LOWER_PEAK_HI 11
`define LOWER_PEAK_LO 8
`define UPPER_PEAK_HI 15
`define UPPER_PEAK_LO 12

// full-power code 00 drops three samples, so the drop count is code plus this base
`define FP_SKIP_BASE 3'h3

// percentage table in 1/1024 units: 25% plus 4.6875% per code step
`define PCT_BASE 10'h100
`define PCT_STEP 10'h030
`define PCT_SHIFT 10

// slow filter averaging weight: ambient moves by a quarter of the error per push
`define AMB_SHIFT 2

// bank 3 word layout, one group of eight words per stage
`define WORD_AMBIENT 3'h0
`define WORD_LAST_PUSH 3'h1
`define WORD_AVG_MAX 3'h2
`define WORD_AVG_MIN 3'h3
`define WORD_UPPER_LIMIT 3'h4
`define WORD_LOWER_LIMIT 3'h5
`define READ_LAST 3'h4
`define WRITE_LAST 3'h5
`define BANK3_DEPTH 64
`define BANK3_AW 6

`endif

// [rtl/bank3_ram.v]
// single-port calibration memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module bank3_ram #(
    parameter WIDTH = 16,
    parameter DEPTH = 64,
    parameter AW = 6
) (
    input wire clock_i,
    input wire wr_en_i,
    input wire [AW-1:0] addr_i,
    input wire [WIDTH-1:0] wr_data_i,
    output reg [WIDTH-1:0] rd_data_o
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // write-first is not needed: the sequencer never uses the read data from a cycle in which it writes
    always @(posedge clock_i) begin
        if (wr_en_i) begin
            mem[addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[addr_i];
    end

endmodule
`default_nettype wire

// [testbench/ambient_cal_chk.sv]
// port-level checks for the ambient calibration block
`timescale 1ns/1ps
`default_nettype none
`include "ambient_cal_consts.vh"
module ambient_cal_chk (
    input wire clock_i,
    input wire rst_n_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [`ADDR_W-1:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire [15:0] reg_rdata_o,
    input wire sample_valid_i,
    input wire busy_o,
    input wire [7:0] contact_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic [15:0] shadow_a;
    logic [15:0] shadow_c;
    // shadow control words so readback is judged without looking inside
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shadow_a <= `CTRL_A_RESET;
            shadow_c <= `CTRL_C_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ADDR_CTRL_A)
                shadow_a <= reg_wdata_i;
            if (reg_addr_i == `ADDR_CTRL_C)
                shadow_c <= reg_wdata_i;
        end
    end
    // one pass: eleven busy cycles (five reads, six writes), then idle
    sequence s_busy_run;
        busy_o [*8] ##1 busy_o [*3];
    endsequence
    sequence s_release;
        !busy_o;
    endsequence
    a_pass_len: assert property ($rose(busy_o) |-> s_busy_run ##1 s_release)
        else $error("pass length wrong");
    a_busy_start: assert property (sample_valid_i && !busy_o |=> busy_o)
        else $error("sample not taken");
    a_idle_quiet: assert property (!busy_o && !sample_valid_i |=> !busy_o)
        else $error("busy without sample");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    a_contact_edge: assert property ($changed(contact_o) |-> $fell(busy_o))
        else $error("contact moved mid pass");
    a_contact_one: assert property ($changed(contact_o) |-> $onehot(contact_o ^ $past(contact_o)))
        else $error("contact moved on two stages");
    a_ctrl_a_back: assert property (reg_rd_i && reg_addr_i == `ADDR_CTRL_A |=> reg_rdata_o == shadow_a)
        else $error("control a readback");
    a_ctrl_c_back: assert property (reg_rd_i && reg_addr_i == `ADDR_CTRL_C |=> reg_rdata_o == shadow_c)
        else $error("control c readback");
    a_contact_read: assert property (reg_rd_i && reg_addr_i == `ADDR_CONTACT
        |=> reg_rdata_o == {8'h00, $past(contact_o)})
        else $error("contact status read");
endmodule
`default_nettype wire

// [testbench/host_model.sv]
// host side of the register port: strobed writes and reads
`timescale 1ns/1ps
`default_nettype none
`include "ambient_cal_consts.vh"
module host_model (
    input wire clock_i,
    input wire [15:0] reg_rdata_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [`ADDR_W-1:0] reg_addr_o,
    output logic [15:0] reg_wdata_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 10'h000;
        reg_wdata_o = 16'h0000;
    end
    // released lines show the inverse so stale values are never mistaken for live ones
    task wr(input [`ADDR_W-1:0] a, input [15:0] d);
        @(negedge clock_i);
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge clock_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    task rd(input [`ADDR_W-1:0] a, output [15:0] d);
        @(negedge clock_i);
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(negedge clock_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
    endtask
    // skip codes written once at setup, code 00 for eight stages
    task setup();
        wr(`ADDR_CTRL_A, 16'h0000);
        wr(`ADDR_CTRL_C, 16'h0000);
    endtask
    // initial offset estimates and sensitivity word for one stage
    task seed(input [2:0] st, input [15:0] up, input [15:0] lo, input [15:0] sens);
        wr(`ADDR_STAGE_BASE + {5'h00, st, 2'h0}, up);
        wr(`ADDR_STAGE_BASE + {5'h00, st, 2'h1}, lo);
        wr(`ADDR_STAGE_BASE + {5'h00, st, 2'h2}, sens);
    endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the ambient calibration block
`timescale 1ns/1ps
`default_nettype none
`include "ambient_cal_consts.vh"
module tb;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sample_valid_i = 1'b0;
    logic [2:0] sample_stage_i = 3'h0;
    logic [15:0] sample_data_i = 16'h0000;
    logic low_power_i = 1'b0;
    wire reg_wr_i;
    wire reg_rd_i;
    wire [`ADDR_W-1:0] reg_addr_i;
    wire [15:0] reg_wdata_i;
    wire [15:0] reg_rdata_o;
    wire busy_o;
    wire [7:0] contact_o;
    integer bad_count = 0;
    integer samples_checked = 0;
    logic [15:0] rv;
    always #10 clock_i = ~clock_i;
    host_model u_host (.clock_i(clock_i), .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
    adaptive_ambient_calibration u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i), .sample_stage_i(sample_stage_i),
        .sample_data_i(sample_data_i), .low_power_i(low_power_i), .busy_o(busy_o),
        .contact_o(contact_o));
    task summarize();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task check(input [15:0] got, input [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    // one converter sample; dup keeps the strobe up while busy to prove it is dropped
    task put(input [2:0] st, input [15:0] d, input dup, input [7:0] exp);
        integer n;
        @(negedge clock_i);
        sample_valid_i = 1'b1;
        sample_stage_i = st;
        sample_data_i = d;
        @(negedge clock_i);
        sample_valid_i = dup;
        sample_data_i = 16'hEA60;
        @(negedge clock_i);
        sample_valid_i = 1'b0;
        n = 0;
        while (busy_o !== 1'b0 && n < 40) begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 40) begin
            $display("FAIL t=%0t busy=%h exp=%h", $time, busy_o, 1'b0);
            bad_count++;
            summarize();
        end
        check({8'h00, contact_o}, {8'h00, exp});
    endtask
    // control, contact and stage 0 words read zero after reset, the hole at stage offset 3 too
    task test_reset();
        logic [`ADDR_W-1:0] adr [0:6];
        integer i;
        adr = '{10'h001, 10'h003, 10'h040, 10'h080, 10'h081, 10'h082, 10'h083};
        for (i = 0; i < 7; i++) begin
            u_host.rd(adr[i], rv);
            check(rv, 16'h0000);
        end
        $display("test_reset done");
    endtask
    // each skip and push-level code lands in its own field and reads back whole
    task test_ctrl();
        integer i;
        for (i = 0; i < 4; i++) begin
            u_host.wr(`ADDR_CTRL_A, {i[1:0], ~i[1:0], 12'h5A5});
            u_host.rd(`ADDR_CTRL_A, rv);
            check(rv, {i[1:0], ~i[1:0], 12'h5A5});
            u_host.wr(`ADDR_CTRL_C, {i[1:0], 14'h1C3A});
            u_host.rd(`ADDR_CTRL_C, rv);
            check(rv, {i[1:0], 14'h1C3A});
        end
        u_host.setup();
        $display("test_ctrl done");
    endtask
    // offsets 100, sensitivity code 8: upper limit near ambient plus 62.5 of 100
    task test_contact();
        u_host.seed(3'h0, 16'h0064, 16'h0064, 16'h0088);
        u_host.rd(10'h082, rv);
        check(rv, 16'h0088);
        put(3'h0, 16'h03E8, 1'b0, 8'h00);
        put(3'h0, 16'h04B0, 1'b0, 8'h01);
        put(3'h0, 16'h03E8, 1'b1, 8'h00);
        put(3'h0, 16'h0384, 1'b0, 8'h01);
        // 1080 would pass the limit set by the offset alone, but the tracked maximum widened it
        put(3'h0, 16'h0438, 1'b0, 8'h00);
        $display("test_contact done");
    endtask
    // stage 3 in low power mode, with zero offsets, keeps its own state
    task test_stages();
        low_power_i = 1'b1;
        put(3'h3, 16'h1388, 1'b0, 8'h00);
        put(3'h3, 16'h1450, 1'b0, 8'h08);
        u_host.rd(`ADDR_CONTACT, rv);
        check(rv, 16'h0008);
        low_power_i = 1'b0;
        $display("test_stages done");
    endtask
    // stage 5: push gate at level 2, skip counting, offsets follow a quarter of the error
    task test_drift();
        low_power_i = 1'b1;
        u_host.wr(`ADDR_CTRL_C, 16'h8000);
        u_host.seed(3'h5, 16'h0100, 16'h0100, 16'h0000);
        put(3'h5, 16'h07D0, 1'b0, 8'h08);
        // a change of 2 is not above level 2, so nothing moves
        put(3'h5, 16'h07D2, 1'b0, 8'h08);
        u_host.rd(10'h094, rv);
        check(rv, 16'h0100);
        // 40 above ambient is pushed: ambient and both offsets move by 10
        put(3'h5, 16'h07F8, 1'b0, 8'h08);
        u_host.rd(10'h094, rv);
        check(rv, 16'h010A);
        u_host.rd(10'h095, rv);
        check(rv, 16'h00F6);
        // full power code 00 drops three samples, the fourth is pushed (50 above, step 12)
        low_power_i = 1'b0;
        put(3'h5, 16'h080C, 1'b0, 8'h08);
        put(3'h5, 16'h080C, 1'b0, 8'h08);
        put(3'h5, 16'h080C, 1'b0, 8'h08);
        u_host.rd(10'h094, rv);
        check(rv, 16'h010A);
        put(3'h5, 16'h080C, 1'b0, 8'h08);
        u_host.rd(10'h094, rv);
        check(rv, 16'h0116);
        $display("test_drift done");
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        @(negedge clock_i);
        rst_n_i = 1'b1;
        test_reset();
        test_ctrl();
        test_contact();
        test_stages();
        test_drift();
        summarize();
    end
endmodule
bind adaptive_ambient_calibration ambient_cal_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i), .busy_o(busy_o),
    .contact_o(contact_o));
`default_nettype wire
